// file: pkg/fap_pkg.sv
// Shared constants and types of the flash access protection block
package fap_pkg;

  // ******************************************************
  // Memory organisation
  // ******************************************************
  localparam int SECTOR_COUNT = 16;
  localparam int SECTOR_BYTES = 1024;
  localparam int EE_BYTES = 512;
  localparam int EE_SECTOR_BYTES = 256;
  localparam int SECT_W = 4;
  localparam int PADDR_W = 14;
  localparam int EEADDR_W = 9;
  localparam int SECT_LSB = 10;
  localparam int OFFS_W = 8;

  // ******************************************************
  // Memory page register fields
  // ******************************************************
  localparam int PAGE_W = 6;
  localparam int PAGE_SECT_LSB = 2;
  localparam int PAGE_EE_BIT = 0;

  // ******************************************************
  // Written-location map: one bit per byte, 64 bytes a word
  // ******************************************************
  localparam int MAP_WORD_W = 64;
  localparam int MAP_BIT_W = 6;
  localparam int MAP_ADDR_W = 9;
  localparam int MAP_DEPTH = 264;
  localparam logic [8:0] MAP_EE_BASE = 9'h100;
  localparam logic [8:0] MAP_LAST = 9'h107;
  localparam logic [8:0] MAP_PROG_LAST = 9'h0FF;
  localparam logic [3:0] MAP_SECT_LAST = 4'hF;

  // ******************************************************
  // Programmer entry sequence
  // ******************************************************
  localparam int ENTRY_KEY_W = 16;
  // Arbitrary key value
  localparam logic [15:0] ENTRY_KEY = 16'hA5C3;

  // ******************************************************
  // Requests
  // ******************************************************
  localparam logic SRC_USER = 1'b0;
  localparam logic SRC_PROG = 1'b1;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_SECTOR_ERASE = 3'h2,
    OP_MASS_ERASE = 3'h3,
    OP_EE_ERASE = 3'h4,
    OP_SET_PROT = 3'h5,
    OP_CODE_READ = 3'h6
  } fap_op_type;

  typedef enum logic [1:0] {
    ST_INIT = 2'h0,
    ST_IDLE = 2'h1,
    ST_WCHK = 2'h2,
    ST_WALK = 2'h3
  } fap_state_type;

endpackage

// file: src/fap_access_ctrl.sv
// Access arbitration and sector protection for program flash and data block
`timescale 1ns/1ps
// Contract
// - Program flash is sixteen 1 KB sectors, checked per sector.
// - A separate 512-byte data block in 256-byte sectors.
// - Mode 0 blocks programmer write and read of a sector, not full erase.
// - Mode 1 blocks code reads from other sectors and self-program erase/write.
// - Only the programmer in its mode may set protection bits.
// - Full erase clears program, options and protection, keeps data block.
// - Full erase only by programmer command in programmer mode.
// - User sector erase only when mode 1 is off for that sector.
// - Programmer sector erase only when mode 0 is off for that sector.
// - Both parties may erase the data block without protection check.
// - User write/read allowed if mode 1 off or sector holds running code.
// - Programmer write/read only if mode 0 off for that sector.
// - Both parties may write and read the data block freely.
// - Programmer mode only after the entry waveform on the four pins.
// - Self-programming takes the target sector from the page register.
// - A written location cannot be rewritten before its sector erase.
module fap_access_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Programming pins
  input wire logic tck_pin,
  input wire logic tdi_pin,
  input wire logic tms_pin,
  input wire logic tdo_pin_in,
  output logic tdo_pin_out,
  output logic tdo_pin_oe_n,
  // CPU context
  input wire logic self_programming_mode,
  input wire logic [fap_pkg::PAGE_W-1:0] memory_page_register,
  input wire logic [fap_pkg::SECT_W-1:0] exec_sector,
  // Request
  input wire logic req_valid,
  input wire logic req_src,
  input wire fap_pkg::fap_op_type req_op,
  input wire logic req_ee,
  input wire logic [fap_pkg::PADDR_W-1:0] req_addr,
  input wire logic [1:0] req_prot_set,
  output logic req_ready,
  // Answer
  output logic resp_valid,
  output logic resp_granted,
  // Command to the flash array
  output logic mem_valid,
  output fap_pkg::fap_op_type mem_op,
  output logic mem_ee,
  output logic [fap_pkg::PADDR_W-1:0] mem_addr,
  // Status
  output logic external_programmer_mode,
  output logic [fap_pkg::SECTOR_COUNT-1:0] prot_mode0,
  output logic [fap_pkg::SECTOR_COUNT-1:0] prot_mode1
);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    fap_pkg::fap_state_type st;
    logic [fap_pkg::SECTOR_COUNT-1:0] prot0;
    logic [fap_pkg::SECTOR_COUNT-1:0] prot1;
    logic ee;
    logic [fap_pkg::PADDR_W-1:0] addr;
    logic [fap_pkg::MAP_ADDR_W-1:0] walk;
    logic [fap_pkg::MAP_ADDR_W-1:0] walk_end;
    logic ready;
    logic resp_valid;
    logic resp_granted;
    logic mem_valid;
    fap_pkg::fap_op_type mem_op;
    logic mem_ee;
    logic [fap_pkg::PADDR_W-1:0] mem_addr;
    logic tdo_out;
    logic tdo_oe_n;
  } fap_ctrl_type;

  fap_ctrl_type r_q;
  fap_ctrl_type r_d;

  logic prog_mode;
  logic map_we;
  logic [fap_pkg::MAP_ADDR_W-1:0] map_waddr;
  logic [fap_pkg::MAP_WORD_W-1:0] map_wdata;
  logic [fap_pkg::MAP_ADDR_W-1:0] map_raddr;
  logic [fap_pkg::MAP_WORD_W-1:0] map_rdata;

  // Request decode
  logic [fap_pkg::PADDR_W-1:0] tgt_addr;
  logic [fap_pkg::SECT_W-1:0] tgt_sect;
  logic own_sect;
  logic mode_ok;
  logic op_ok;

  // ******************************************************
  // Helpers
  // ******************************************************
  // Map word index of a byte; data block words sit above program words
  function automatic logic [fap_pkg::MAP_ADDR_W-1:0] map_index(
    input logic ee,
    input logic [fap_pkg::PADDR_W-1:0] a
  );
    logic [fap_pkg::MAP_ADDR_W-1:0] idx;
    if (ee) begin
      idx = fap_pkg::MAP_EE_BASE | {6'h00, a[fap_pkg::EEADDR_W-1:fap_pkg::MAP_BIT_W]};
    end else begin
      idx = {1'b0, a[fap_pkg::PADDR_W-1:fap_pkg::MAP_BIT_W]};
    end
    return idx;
  endfunction

  // ******************************************************
  // Submodules
  // ******************************************************
  fap_entry_detect u_entry (
    .clk(clk),
    .rst(rst),
    .tck_pin(tck_pin),
    .tdi_pin(tdi_pin),
    .tms_pin(tms_pin),
    .tdo_pin_in(tdo_pin_in),
    .prog_mode_q(prog_mode)
  );

  fap_written_map u_map (
    .clk(clk),
    .we(map_we),
    .waddr(map_waddr),
    .wdata(map_wdata),
    .raddr(map_raddr),
    .rdata_q(map_rdata)
  );

  // ******************************************************
  // Outputs
  // ******************************************************
  assign tdo_pin_out = r_q.tdo_out;
  assign tdo_pin_oe_n = r_q.tdo_oe_n;
  assign req_ready = r_q.ready;
  assign resp_valid = r_q.resp_valid;
  assign resp_granted = r_q.resp_granted;
  assign mem_valid = r_q.mem_valid;
  assign mem_op = r_q.mem_op;
  assign mem_ee = r_q.mem_ee;
  assign mem_addr = r_q.mem_addr;
  assign external_programmer_mode = prog_mode;
  assign prot_mode0 = r_q.prot0;
  assign prot_mode1 = r_q.prot1;

  // ******************************************************
  // Permission check
  // ******************************************************
  always_comb begin
    // Self-programming ignores the upper address and uses the page register
    if (req_src == fap_pkg::SRC_USER && req_op != fap_pkg::OP_CODE_READ) begin
      if (req_ee) begin
        tgt_addr = {5'h00, memory_page_register[fap_pkg::PAGE_EE_BIT], req_addr[fap_pkg::OFFS_W-1:0]};
      end else begin
        tgt_addr = {memory_page_register, req_addr[fap_pkg::OFFS_W-1:0]};
      end
    end else if (req_ee) begin
      tgt_addr = {5'h00, req_addr[fap_pkg::EEADDR_W-1:0]};
    end else begin
      tgt_addr = req_addr;
    end
    tgt_sect = tgt_addr[fap_pkg::PADDR_W-1:fap_pkg::SECT_LSB];
    own_sect = (tgt_sect == exec_sector);
    if (req_src == fap_pkg::SRC_PROG) begin
      mode_ok = prog_mode;
    end else begin
      mode_ok = self_programming_mode || req_op == fap_pkg::OP_CODE_READ;
    end
    case (req_op)
      fap_pkg::OP_READ, fap_pkg::OP_WRITE: begin
        if (req_ee) begin
          op_ok = 1'b1;
        end else if (req_src == fap_pkg::SRC_PROG) begin
          op_ok = !r_q.prot0[tgt_sect];
        end else begin
          op_ok = !r_q.prot1[tgt_sect] || own_sect;
        end
      end
      fap_pkg::OP_CODE_READ: begin
        op_ok = req_src == fap_pkg::SRC_USER && !req_ee && (!r_q.prot1[tgt_sect] || own_sect);
      end
      fap_pkg::OP_SECTOR_ERASE: begin
        if (req_ee) begin
          op_ok = 1'b0;
        end else if (req_src == fap_pkg::SRC_PROG) begin
          op_ok = !r_q.prot0[tgt_sect];
        end else begin
          op_ok = !r_q.prot1[tgt_sect];
        end
      end
      fap_pkg::OP_MASS_ERASE: begin
        op_ok = req_src == fap_pkg::SRC_PROG;
      end
      fap_pkg::OP_EE_ERASE: begin
        op_ok = 1'b1;
      end
      fap_pkg::OP_SET_PROT: begin
        op_ok = req_src == fap_pkg::SRC_PROG && !req_ee;
      end
      default: begin
        op_ok = 1'b0;
      end
    endcase
  end

  // ******************************************************
  // Sequencer
  // ******************************************************
  always_comb begin
    r_d = r_q;
    r_d.resp_valid = 1'b0;
    r_d.resp_granted = 1'b0;
    r_d.mem_valid = 1'b0;
    map_we = 1'b0;
    map_waddr = r_q.walk;
    map_wdata = '0;
    map_raddr = map_index(req_ee, tgt_addr);
    case (r_q.st)
      // Clear the whole map once; flash contents are unknown to it
      fap_pkg::ST_INIT: begin
        map_we = 1'b1;
        if (r_q.walk == fap_pkg::MAP_LAST) begin
          r_d.st = fap_pkg::ST_IDLE;
          r_d.ready = 1'b1;
          r_d.walk = '0;
        end else begin
          r_d.walk = r_q.walk + 9'h001;
        end
      end
      fap_pkg::ST_IDLE: begin
        if (req_valid) begin
          r_d.ee = req_ee;
          r_d.addr = tgt_addr;
          r_d.mem_op = req_op;
          r_d.mem_ee = req_ee;
          r_d.mem_addr = tgt_addr;
          if (!(mode_ok && op_ok)) begin
            r_d.resp_valid = 1'b1;
          end else begin
            case (req_op)
              fap_pkg::OP_WRITE: begin
                r_d.st = fap_pkg::ST_WCHK;
                r_d.ready = 1'b0;
              end
              fap_pkg::OP_SECTOR_ERASE: begin
                r_d.walk = {1'b0, tgt_sect, 4'h0};
                r_d.walk_end = {1'b0, tgt_sect, fap_pkg::MAP_SECT_LAST};
                r_d.mem_valid = 1'b1;
                r_d.st = fap_pkg::ST_WALK;
                r_d.ready = 1'b0;
              end
              fap_pkg::OP_EE_ERASE: begin
                r_d.walk = fap_pkg::MAP_EE_BASE;
                r_d.walk_end = fap_pkg::MAP_LAST;
                r_d.mem_valid = 1'b1;
                r_d.st = fap_pkg::ST_WALK;
                r_d.ready = 1'b0;
              end
              fap_pkg::OP_MASS_ERASE: begin
                // Data block words lie above the walk range, so they survive
                r_d.prot0 = '0;
                r_d.prot1 = '0;
                r_d.walk = '0;
                r_d.walk_end = fap_pkg::MAP_PROG_LAST;
                r_d.mem_valid = 1'b1;
                r_d.st = fap_pkg::ST_WALK;
                r_d.ready = 1'b0;
              end
              fap_pkg::OP_SET_PROT: begin
                // Bits only set; only a full erase or a reset brings them back
                r_d.prot0[tgt_sect] = r_q.prot0[tgt_sect] | req_prot_set[0];
                r_d.prot1[tgt_sect] = r_q.prot1[tgt_sect] | req_prot_set[1];
                r_d.resp_valid = 1'b1;
                r_d.resp_granted = 1'b1;
              end
              default: begin
                r_d.mem_valid = 1'b1;
                r_d.resp_valid = 1'b1;
                r_d.resp_granted = 1'b1;
              end
            endcase
          end
        end
      end
      // Map word arrives one cycle after the request was taken
      fap_pkg::ST_WCHK: begin
        r_d.st = fap_pkg::ST_IDLE;
        r_d.ready = 1'b1;
        r_d.resp_valid = 1'b1;
        if (!map_rdata[r_q.addr[fap_pkg::MAP_BIT_W-1:0]]) begin
          map_we = 1'b1;
          map_waddr = map_index(r_q.ee, r_q.addr);
          map_wdata = map_rdata | (64'h0000000000000001 << r_q.addr[fap_pkg::MAP_BIT_W-1:0]);
          r_d.mem_valid = 1'b1;
          r_d.resp_granted = 1'b1;
        end
      end
      fap_pkg::ST_WALK: begin
        map_we = 1'b1;
        if (r_q.walk == r_q.walk_end) begin
          r_d.st = fap_pkg::ST_IDLE;
          r_d.ready = 1'b1;
          r_d.resp_valid = 1'b1;
          r_d.resp_granted = 1'b1;
        end else begin
          r_d.walk = r_q.walk + 9'h001;
        end
      end
      default: begin
        r_d.st = fap_pkg::ST_IDLE;
        r_d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
      r_q.tdo_oe_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

endmodule

// file: src/fap_entry_detect.sv
// Recognises the programmer entry waveform on the four pins
`timescale 1ns/1ps
module fap_entry_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins, asynchronous to clk
  input wire logic tck_pin,
  input wire logic tdi_pin,
  input wire logic tms_pin,
  input wire logic tdo_pin_in,
  // Mode
  output logic prog_mode_q
);

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic tck_last;
    logic [fap_pkg::ENTRY_KEY_W-1:0] shift;
    logic mode;
  } fap_entry_type;

  fap_entry_type r_q;
  fap_entry_type r_d;

  assign prog_mode_q = r_q.mode;

  always_comb begin
    r_d = r_q;
    r_d.sync1 = {tdo_pin_in, tms_pin, tdi_pin, tck_pin};
    r_d.sync2 = r_q.sync1;
    r_d.tck_last = r_q.sync2[0];
    // Frame requires TMS high and TDO low; anything else restarts the key
    if (!r_q.sync2[2] || r_q.sync2[3]) begin
      r_d.shift = '0;
    end else if (r_q.sync2[0] && !r_q.tck_last) begin
      r_d.shift = {r_q.shift[fap_pkg::ENTRY_KEY_W-2:0], r_q.sync2[1]};
    end
    // Sticky until reset; mode only follows a full key
    if (r_q.shift == fap_pkg::ENTRY_KEY) begin
      r_d.mode = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

endmodule

// file: src/fap_written_map.sv
// Memory of written-location flags with registered read data
`timescale 1ns/1ps
module fap_written_map (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [fap_pkg::MAP_ADDR_W-1:0] waddr,
  input wire logic [fap_pkg::MAP_WORD_W-1:0] wdata,
  // Read port
  input wire logic [fap_pkg::MAP_ADDR_W-1:0] raddr,
  output logic [fap_pkg::MAP_WORD_W-1:0] rdata_q
);

  // No reset on the array; the controller clears it after reset
  logic [fap_pkg::MAP_WORD_W-1:0] mem [0:fap_pkg::MAP_DEPTH-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule

// file: tb/fap_access_assertions.sv
// Concurrent checks on the ports of the flash access protection block
`timescale 1ns/1ps
module fap_access_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Context and request
  input wire logic self_programming_mode,
  input wire logic [5:0] memory_page_register,
  input wire logic [3:0] exec_sector,
  input wire logic req_valid,
  input wire logic req_src,
  input wire fap_pkg::fap_op_type req_op,
  input wire logic req_ee,
  input wire logic [13:0] req_addr,
  input wire logic req_ready,
  // Answer and state
  input wire logic resp_valid,
  input wire logic resp_granted,
  input wire logic mem_valid,
  input wire logic external_programmer_mode,
  input wire logic [15:0] prot_mode0,
  input wire logic [15:0] prot_mode1
);
  logic take, prog, user, p_bad, u_ok;
  assign take = req_valid && req_ready;
  assign prog = take && req_src == fap_pkg::SRC_PROG && external_programmer_mode;
  assign user = take && req_src == fap_pkg::SRC_USER && self_programming_mode;
  assign p_bad = prot_mode0[req_addr[13:10]];
  assign u_ok = !prot_mode1[memory_page_register[5:2]] || memory_page_register[5:2] == exec_sector;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_refuse_no_mem: assert property (resp_valid && !resp_granted |-> !mem_valid)
    else $error("refused request reached the array");
  a_user_no_mass: assert property (take && req_src == fap_pkg::SRC_USER && req_op == fap_pkg::OP_MASS_ERASE
    |=> resp_valid && !resp_granted) else $error("user full erase not refused");
  a_user_no_prot: assert property (take && req_src == fap_pkg::SRC_USER && req_op == fap_pkg::OP_SET_PROT
    |=> resp_valid && !resp_granted && $stable(prot_mode0) && $stable(prot_mode1))
    else $error("user changed protection");
  a_prog_gate: assert property (take && req_src == fap_pkg::SRC_PROG && !external_programmer_mode
    |=> resp_valid && !resp_granted) else $error("programmer served outside its mode");
  a_prog_read_prot: assert property (prog && req_op == fap_pkg::OP_READ && !req_ee
    |=> resp_valid && resp_granted == !$past(p_bad)) else $error("programmer read grant wrong");
  a_user_read_prot: assert property (user && req_op == fap_pkg::OP_READ && !req_ee
    |=> resp_valid && resp_granted == $past(u_ok)) else $error("user read grant wrong");
  a_user_erase_prot: assert property (user && req_op == fap_pkg::OP_SECTOR_ERASE && !req_ee
    && prot_mode1[memory_page_register[5:2]] |=> resp_valid && !resp_granted)
    else $error("user erase of protected sector");
  a_prog_erase_prot: assert property (prog && req_op == fap_pkg::OP_SECTOR_ERASE && !req_ee && p_bad
    |=> resp_valid && !resp_granted) else $error("programmer erase of protected sector");
  a_mass_clears: assert property (prog && req_op == fap_pkg::OP_MASS_ERASE
    |=> prot_mode0 == 16'h0000 && prot_mode1 == 16'h0000) else $error("full erase left protection");
  a_data_erase_ok: assert property ((prog || user) && req_op == fap_pkg::OP_EE_ERASE
    |=> !req_ready ##7 !resp_valid ##1 resp_valid && resp_granted) else $error("data block erase wrong");
endmodule
bind fap_access_ctrl fap_access_assertions chk (.clk(clk), .rst(rst),
  .self_programming_mode(self_programming_mode), .memory_page_register(memory_page_register),
  .exec_sector(exec_sector), .req_valid(req_valid), .req_src(req_src), .req_op(req_op), .req_ee(req_ee),
  .req_addr(req_addr), .req_ready(req_ready), .resp_valid(resp_valid), .resp_granted(resp_granted),
  .mem_valid(mem_valid), .external_programmer_mode(external_programmer_mode),
  .prot_mode0(prot_mode0), .prot_mode1(prot_mode1));

// file: tb/fap_prog_model.sv
// Behavioural programmer that drives the entry waveform on the four pins
`timescale 1ns/1ps
module fap_prog_model (
  // Frame request
  input wire logic start,
  input wire logic [15:0] key,
  // Pins
  output logic tck,
  output logic tdi,
  output logic tms,
  output logic tdo
);
  initial begin
    tck = 1'b0;
    tdi = 1'b0;
    tms = 1'b0;
    tdo = 1'b1;
  end
  // Clock stands still between frames; the released data line flips so no stale bit lingers
  always @(posedge start) begin
    tms = 1'b1;
    tdo = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tdi = key[i];
      #40 tck = 1'b1;
      #80 tck = 1'b0;
      #40;
    end
    tms = 1'b0;
    tdo = 1'b1;
    tdi = ~tdi;
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the flash access protection block
`timescale 1ns/1ps
module testbench;
  localparam logic P = fap_pkg::SRC_PROG;
  localparam logic U = fap_pkg::SRC_USER;
  localparam fap_pkg::fap_op_type RD = fap_pkg::OP_READ;
  localparam fap_pkg::fap_op_type WR = fap_pkg::OP_WRITE;
  localparam fap_pkg::fap_op_type SE = fap_pkg::OP_SECTOR_ERASE;
  localparam fap_pkg::fap_op_type SP = fap_pkg::OP_SET_PROT;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic tck, tdi, tms, tdo_prog, tdo_out, tdo_oe_n, tdo_wire;
  logic spm = 1'b0;
  logic [5:0] page = 6'h00;
  logic [3:0] exec = 4'h0;
  logic req_valid = 1'b0;
  logic req_src = 1'b0;
  fap_pkg::fap_op_type req_op = fap_pkg::OP_READ;
  logic req_ee = 1'b0;
  logic [13:0] req_addr = 14'h0000;
  logic [1:0] req_prot = 2'h0;
  logic req_ready, resp_valid, resp_granted, mem_valid, mem_ee, epm;
  fap_pkg::fap_op_type mem_op;
  logic [13:0] mem_addr;
  logic [15:0] pm0, pm1, m0, m1;
  logic start = 1'b0;
  logic [15:0] key = 16'h0000;
  logic [31:0] seed = 32'h0000_9485;
  logic [31:0] r;
  // Note layout: grant, array strobe, data block, op, target address
  logic [19:0] expq[$];
  logic [19:0] e;
  int fails = 0;
  int compares = 0;
  int nresp = 0;
  int cycles = 0;

  always #5 clk = ~clk;
  // Device never drives its data-out pin, so the programmer's level wins
  assign tdo_wire = tdo_oe_n ? tdo_prog : tdo_out;

  fap_access_ctrl uut (.clk(clk), .rst(rst), .tck_pin(tck), .tdi_pin(tdi), .tms_pin(tms),
    .tdo_pin_in(tdo_wire), .tdo_pin_out(tdo_out), .tdo_pin_oe_n(tdo_oe_n), .self_programming_mode(spm),
    .memory_page_register(page), .exec_sector(exec), .req_valid(req_valid), .req_src(req_src),
    .req_op(req_op), .req_ee(req_ee), .req_addr(req_addr), .req_prot_set(req_prot), .req_ready(req_ready),
    .resp_valid(resp_valid), .resp_granted(resp_granted), .mem_valid(mem_valid), .mem_op(mem_op),
    .mem_ee(mem_ee), .mem_addr(mem_addr), .external_programmer_mode(epm), .prot_mode0(pm0), .prot_mode1(pm1));
  fap_prog_model u_prog (.start(start), .key(key), .tck(tck), .tdi(tdi), .tms(tms), .tdo(tdo_prog));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Called at a falling edge; the request is held until the edge that takes it
  task automatic req(input logic s, input fap_pkg::fap_op_type op, input logic ee, input logic [13:0] a,
                     input logic [1:0] ps, input logic exp);
    int n;
    n = nresp;
    expq.push_back({exp, exp && (op == RD || op == WR || op == fap_pkg::OP_CODE_READ), ee, op,
                    ee ? {5'h00, a[8:0]} : a});
    req_src = s;
    req_op = op;
    req_ee = ee;
    req_addr = a;
    req_prot = ps;
    page = a[13:8];
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    repeat (400) if (nresp == n) @(negedge clk);
    if (nresp == n) check("answer", 16'h0000, 16'h0001);
  endtask

  task automatic send_key(input logic [15:0] k);
    key = k;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (300) @(negedge clk);
  endtask

  // Oldest noted expectation is matched to each answer pulse
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      stop_test();
    end
    if (resp_valid === 1'b1) begin
      if (expq.size() == 0) begin
        check("spare answer", 16'h0001, 16'h0000);
      end else begin
        e = expq.pop_front();
        check("grant", {15'h0000, resp_granted}, {15'h0000, e[19]});
        check("array strobe", {15'h0000, mem_valid}, {15'h0000, e[18]});
        if (e[19]) begin
          check("array op", {12'h000, mem_ee, mem_op}, {12'h000, e[17:14]});
          check("array address", {2'h0, mem_addr}, {2'h0, e[13:0]});
        end
      end
      nresp++;
    end
  end

  initial begin
    repeat (10) @(negedge clk);
    check("ready in reset", {15'h0000, req_ready}, 16'h0000);
    rst = 1'b0;
    repeat (263) @(negedge clk);
    check("ready early", {15'h0000, req_ready}, 16'h0000);
    @(negedge clk);
    check("ready", {15'h0000, req_ready}, 16'h0001);
    $display("test reset done");
    req(P, RD, 1'h0, 14'h0000, 2'h0, 1'h0);
    send_key(~fap_pkg::ENTRY_KEY);
    check("mode wrong key", {15'h0000, epm}, 16'h0000);
    send_key(fap_pkg::ENTRY_KEY);
    check("mode", {15'h0000, epm}, 16'h0001);
    check("data pin", {14'h0000, tdo_oe_n, tdo_out}, 16'h0002);
    $display("test entry done");
    spm = 1'b1;
    req(U, SP, 1'h0, 14'h0C00, 2'h3, 1'h0);
    req(U, fap_pkg::OP_MASS_ERASE, 1'h0, 14'h0000, 2'h0, 1'h0);
    req(P, SP, 1'h0, 14'h0C00, 2'h1, 1'h1);
    req(P, SP, 1'h0, 14'h1400, 2'h2, 1'h1);
    check("mode0 bits", pm0, 16'h0008);
    check("mode1 bits", pm1, 16'h0020);
    req(P, RD, 1'h0, 14'h0C10, 2'h0, 1'h0);
    req(P, WR, 1'h0, 14'h0C10, 2'h0, 1'h0);
    req(P, SE, 1'h0, 14'h0C00, 2'h0, 1'h0);
    req(P, RD, 1'h0, 14'h1400, 2'h0, 1'h1);
    req(P, WR, 1'h0, 14'h1000, 2'h0, 1'h1);
    req(P, WR, 1'h0, 14'h1000, 2'h0, 1'h0);
    req(P, SE, 1'h0, 14'h1000, 2'h0, 1'h1);
    req(P, WR, 1'h0, 14'h1000, 2'h0, 1'h1);
    $display("test programmer done");
    req(U, RD, 1'h0, 14'h1400, 2'h0, 1'h0);
    req(U, WR, 1'h0, 14'h1400, 2'h0, 1'h0);
    req(U, fap_pkg::OP_CODE_READ, 1'h0, 14'h1400, 2'h0, 1'h0);
    exec = 4'h5;
    req(U, WR, 1'h0, 14'h1401, 2'h0, 1'h1);
    req(U, RD, 1'h0, 14'h1401, 2'h0, 1'h1);
    req(U, SE, 1'h0, 14'h1400, 2'h0, 1'h0);
    req(U, SE, 1'h0, 14'h1800, 2'h0, 1'h1);
    $display("test user done");
    req(U, WR, 1'h1, 14'h0010, 2'h0, 1'h1);
    req(U, WR, 1'h1, 14'h0010, 2'h0, 1'h0);
    req(U, fap_pkg::OP_EE_ERASE, 1'h1, 14'h0000, 2'h0, 1'h1);
    req(P, WR, 1'h1, 14'h0110, 2'h0, 1'h1);
    req(P, fap_pkg::OP_EE_ERASE, 1'h1, 14'h0000, 2'h0, 1'h1);
    req(U, WR, 1'h1, 14'h0010, 2'h0, 1'h1);
    req(P, fap_pkg::OP_MASS_ERASE, 1'h0, 14'h0000, 2'h0, 1'h1);
    check("mode0 cleared", pm0, 16'h0000);
    check("mode1 cleared", pm1, 16'h0000);
    req(P, RD, 1'h0, 14'h0C10, 2'h0, 1'h1);
    req(U, WR, 1'h1, 14'h0010, 2'h0, 1'h0);
    $display("test erase done");
    m0 = 16'h0000;
    m1 = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      r = xs();
      req(P, SP, 1'h0, r[13:0], r[15:14], 1'h1);
      // Setting only ever adds bits, so a repeated sector accumulates them
      m0[r[13:10]] = m0[r[13:10]] | r[14];
      m1[r[13:10]] = m1[r[13:10]] | r[15];
    end
    for (int i = 0; i < 16; i++) begin
      r = xs();
      exec = r[19:16];
      req(P, RD, 1'h0, r[13:0], 2'h0, !m0[r[13:10]]);
      req(U, RD, 1'h0, r[13:0], 2'h0, !m1[r[13:10]] || r[13:10] == r[19:16]);
    end
    $display("test random done");
    stop_test();
  end
endmodule
